/* File: src/adc_cal_pkg.sv */
// Constants, tables and types for the conversion and calibration block.
// Assumes an APB register bus and a master clock sampled by the bus clock.
package adc_cal_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam logic [7:0] REG_GAIN = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // Command codes written to the command register
  localparam logic [3:0] CMD_WAKEUP = 4'h0;
  localparam logic [3:0] CMD_SYNC = 4'h1;
  localparam logic [3:0] CMD_STANDBY = 4'h2;
  localparam logic [3:0] CMD_SELF_OFS = 4'h3;
  localparam logic [3:0] CMD_SELF_GAIN = 4'h4;
  localparam logic [3:0] CMD_SELF_FULL = 4'h5;
  localparam logic [3:0] CMD_SYS_OFS = 4'h6;
  localparam logic [3:0] CMD_SYS_GAIN = 4'h7;

  // Status bit positions
  localparam int ST_BIT_READY = 0;
  localparam int ST_BIT_CAL = 1;
  localparam int ST_BIT_STANDBY = 2;
  localparam int ST_BIT_ONESHOT = 3;

  // Analog input routing codes
  localparam logic [1:0] INPUT_SIGNAL = 2'h0;
  localparam logic [1:0] INPUT_MIDSUPPLY = 2'h1;
  localparam logic [1:0] INPUT_REFERENCE = 2'h2;

  localparam int RATE_COUNT = 16;
  localparam int GROUP_COUNT = 5;

  // Master clock periods per output sample, fastest rate first
  localparam logic [21:0] PERIOD_MCLK [RATE_COUNT] = '{
    22'h000100, 22'h000200, 22'h000400, 22'h000800,
    22'h000f00, 22'h001e00, 22'h003c00, 22'h012c00,
    22'h01f400, 22'h025800, 22'h03e800, 22'h04b000,
    22'h07d000, 22'h0bb800, 22'h177000, 22'h2ee000};

  // Data-ready periods to a settled result
  localparam logic [2:0] SETTLE_PERIODS [RATE_COUNT] = '{
    3'h5, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};

  // Scaling group per rate
  localparam logic [2:0] RATE_GROUP [RATE_COUNT] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2,
    3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};

  localparam logic [23:0] ALPHA [GROUP_COUNT] = '{
    24'h400000, 24'h3c0000, 24'h4b0000, 24'h3e8000, 24'h5dc000};
  // Beta times 2^16
  localparam logic [17:0] BETA_Q16 [GROUP_COUNT] = '{
    18'h1dd29, 18'h1bf55, 18'h22f2f, 18'h1d1fa, 18'h2bafc};
  localparam logic [23:0] IDEAL_GAIN [GROUP_COUNT] = '{
    24'h44ac08, 24'h494008, 24'h3a99a0, 24'h4651f3, 24'h2ee14c};

  localparam int BETA_FRAC = 16;
  localparam int CODE_FRAC = 23;
  localparam int RECIP_SHIFT = CODE_FRAC + BETA_FRAC;
  localparam int OUT_SHIFT = CODE_FRAC + BETA_FRAC;

  // 2^39 / alpha, so offset over alpha is a multiply and a shift
  localparam logic [17:0] ALPHA_RECIP [GROUP_COUNT] = '{
    18'((64'h1 << RECIP_SHIFT) / 64'(ALPHA[0])),
    18'((64'h1 << RECIP_SHIFT) / 64'(ALPHA[1])),
    18'((64'h1 << RECIP_SHIFT) / 64'(ALPHA[2])),
    18'((64'h1 << RECIP_SHIFT) / 64'(ALPHA[3])),
    18'((64'h1 << RECIP_SHIFT) / 64'(ALPHA[4]))};

  localparam logic [23:0] CODE_MAX = 24'h7fffff;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET = IDEAL_GAIN[0];
  localparam logic [3:0] RATE_RESET = 4'h0;

  // Modulator power-up, in master clocks
  localparam int MOD_CLK_DIV = 4;
  localparam int POWERUP_MOD_CLKS = 64;
  localparam logic [21:0] POWERUP_MCLK = 22'(POWERUP_MOD_CLKS * MOD_CLK_DIV);
  localparam logic [21:0] DATA_READY_N_HIGH_MCLK = 22'h000004;
  localparam logic [2:0] CAL_EXTRA_PERIODS = 3'h1;

  // Gain division: numerator is 2^62
  localparam logic [5:0] DIV_STEPS = 6'h3f;
  localparam logic [5:0] DIV_FIRST = 6'h00;

  typedef enum {
    ST_CAL_OFS,
    ST_CAL_GAIN,
    ST_DIVIDE,
    ST_SYNC,
    ST_STANDBY,
    ST_POWERUP,
    ST_SETTLE,
    ST_RUN
  } state_t;

endpackage : adc_cal_pkg

/* File: src/adc_conversion_and_calibration.sv */
// Conversion sequencing, output coding and offset/gain calibration.
// Assumes filterCode comes from filter logic on clk; master clock and
// sync pin are asynchronous and are synchronised here.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps

module adc_conversion_and_calibration
  import adc_cal_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic masterClockInput,
  input wire logic syncPowerdownN,
  input wire logic [23:0] filterCode,
  output logic dataReadyN,
  output logic [1:0] analogInputSel,
  output logic modulatorPowered
);

  // Synchronisers
  logic mclkMeta;
  logic mclkSync;
  logic mclkPrev;
  logic syncMeta;
  logic syncSync;
  logic syncPrev;
  logic mclkTick;
  logic syncLow;
  logic syncRise;

  // Sequencing
  state_t state;
  state_t next_state;
  logic restart;
  logic oneShot;
  logic calSystem;
  logic calFull;
  logic [21:0] tickCnt;
  logic [2:0] perCnt;
  logic periodDone;
  logic settleDone;
  logic calDone;
  logic powerupDone;
  logic drdyEarly;
  logic conversionDone;
  logic deliverOk;

  // Registers
  logic [3:0] rateSel;
  logic [23:0] offsetWord;
  logic [23:0] gainWord;
  logic [23:0] dataWord;
  logic [2:0] group;
  logic [21:0] periodLen;
  logic [2:0] settleLen;

  // Bus decode
  logic apbAccess;
  logic apbWrite;
  logic cmdValid;
  logic [3:0] cmdCode;
  logic calOfsCmd;
  logic calGainCmd;
  logic dataRead;
  logic [31:0] readData;
  logic readErr;
  logic writeErr;

  // Arithmetic
  logic signed [42:0] ofsScaled;
  logic signed [27:0] corrDiff;
  logic signed [71:0] corrProd;
  logic [23:0] corrOut;
  logic signed [48:0] ofsMeas;
  logic [23:0] newOffset;
  logic signed [46:0] gainProd;

  // Divider
  logic [5:0] divStep;
  logic [46:0] divisor;
  logic [47:0] rem;
  logic [47:0] trial;
  logic trialGe;
  logic [24:0] quot;
  logic quotOvf;
  logic gainBad;
  logic [23:0] newGain;

  function automatic logic [23:0] sat24(input logic signed [71:0] v);
    logic signed [71:0] hi;
    logic signed [71:0] lo;
    hi = $signed({48'h0, CODE_MAX});
    lo = $signed({{48{1'b1}}, CODE_MIN});
    if (v > hi) begin
      sat24 = CODE_MAX;
    end else if (v < lo) begin
      sat24 = CODE_MIN;
    end else begin
      sat24 = v[23:0];
    end
  endfunction : sat24

  // Master clock and sync pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      mclkMeta <= 1'b0;
      mclkSync <= 1'b0;
      mclkPrev <= 1'b0;
      syncMeta <= 1'b1;
      syncSync <= 1'b1;
      syncPrev <= 1'b1;
    end else if (ce) begin
      mclkMeta <= masterClockInput;
      mclkSync <= mclkMeta;
      mclkPrev <= mclkSync;
      syncMeta <= syncPowerdownN;
      syncSync <= syncMeta;
      syncPrev <= syncSync;
    end
  end

  assign mclkTick = mclkSync & ~mclkPrev;
  assign syncLow = ~syncSync;
  assign syncRise = syncSync & ~syncPrev;

  // Per-rate selections
  assign group = RATE_GROUP[rateSel];
  assign periodLen = PERIOD_MCLK[rateSel];
  assign settleLen = SETTLE_PERIODS[rateSel];

  // Bus decode
  assign apbAccess = psel & penable & pready;
  assign apbWrite = apbAccess & pwrite;
  assign cmdValid = apbWrite & (paddr == REG_CMD);
  assign cmdCode = pwdata[3:0];
  assign calOfsCmd = cmdValid & ((cmdCode == CMD_SELF_OFS) |
    (cmdCode == CMD_SELF_FULL) | (cmdCode == CMD_SYS_OFS));
  assign calGainCmd = cmdValid & ((cmdCode == CMD_SELF_GAIN) |
    (cmdCode == CMD_SYS_GAIN));
  assign dataRead = apbAccess & ~pwrite & (paddr == REG_DATA);

  // Timing events, all in master clocks
  assign periodDone = mclkTick & (tickCnt == periodLen - 22'h000001);
  assign settleDone = periodDone & (perCnt == settleLen - 3'h1);
  assign calDone = periodDone &
    (perCnt == settleLen + CAL_EXTRA_PERIODS - 3'h1);
  assign powerupDone = mclkTick &
    (tickCnt == POWERUP_MCLK - 22'h000001);
  assign drdyEarly = (state == ST_RUN) & mclkTick &
    (tickCnt == periodLen - DATA_READY_N_HIGH_MCLK - 22'h000001);
  assign conversionDone = ((state == ST_SETTLE) & settleDone) |
    ((state == ST_RUN) & periodDone);
  // Result dropped when a command leaves the conversion path
  assign deliverOk = ((state == ST_SETTLE) & oneShot) ?
    (next_state == ST_STANDBY) : (next_state == ST_RUN);

  // Correction arithmetic
  assign ofsScaled = $signed(offsetWord) *
    $signed({1'b0, ALPHA_RECIP[group]});
  assign corrDiff = 28'($signed(filterCode)) -
    28'(ofsScaled >>> BETA_FRAC);
  assign corrProd = corrDiff * $signed({1'b0, gainWord}) *
    $signed({1'b0, BETA_Q16[group]});
  assign corrOut = sat24(corrProd >>> OUT_SHIFT);
  assign ofsMeas = $signed(filterCode) * $signed({1'b0, ALPHA[group]});
  assign newOffset = sat24(72'(ofsMeas >>> CODE_FRAC));
  assign gainProd = corrDiff * $signed({1'b0, BETA_Q16[group]});

  // Gain division step
  assign trial = {rem[46:0], divStep == DIV_FIRST};
  assign trialGe = trial >= {1'b0, divisor};
  assign newGain = (gainBad | quotOvf | quot[24]) ? 24'hffffff : quot[23:0];

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_CAL_OFS: begin
        if (calDone) begin
          next_state = calFull ? ST_CAL_GAIN : ST_SETTLE;
        end
      end
      ST_CAL_GAIN: begin
        if (calDone) begin
          next_state = ST_DIVIDE;
        end
      end
      ST_DIVIDE: begin
        if (divStep == DIV_STEPS) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SYNC: begin
        if (syncRise | (cmdValid & (cmdCode == CMD_WAKEUP))) begin
          next_state = ST_SETTLE;
        end
      end
      ST_STANDBY: begin
        if (cmdValid & (cmdCode == CMD_WAKEUP)) begin
          next_state = ST_POWERUP;
        end
      end
      ST_POWERUP: begin
        if (powerupDone) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settleDone) begin
          next_state = oneShot ? ST_STANDBY : ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_CAL_OFS;
      end
    endcase
    if (cmdValid & (cmdCode == CMD_SYNC)) begin
      next_state = ST_SYNC;
    end
    if (cmdValid & (cmdCode == CMD_STANDBY)) begin
      next_state = ST_STANDBY;
    end
    if (calOfsCmd) begin
      next_state = ST_CAL_OFS;
    end
    if (calGainCmd) begin
      next_state = ST_CAL_GAIN;
    end
    if (syncLow) begin
      next_state = ST_SYNC;
    end
  end

  assign restart = (next_state != state) | calOfsCmd | calGainCmd;

  // State and calibration kind
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_CAL_OFS;
      calFull <= 1'b1;
      calSystem <= 1'b0;
      oneShot <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (calOfsCmd | calGainCmd) begin
        calFull <= cmdCode == CMD_SELF_FULL;
        calSystem <= (cmdCode == CMD_SYS_OFS) | (cmdCode == CMD_SYS_GAIN);
      end
      if ((state == ST_STANDBY) & (next_state == ST_POWERUP)) begin
        oneShot <= 1'b1;
      end else if (restart & (next_state != ST_POWERUP) &
          (next_state != ST_SETTLE) & (next_state != ST_STANDBY)) begin
        oneShot <= 1'b0;
      end
    end
  end

  // Master clock counters
  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt <= '0;
      perCnt <= '0;
    end else if (ce) begin
      if (restart) begin
        tickCnt <= '0;
        perCnt <= '0;
      end else if (periodDone) begin
        tickCnt <= '0;
        perCnt <= perCnt + 3'h1;
      end else if (mclkTick) begin
        tickCnt <= tickCnt + 22'h000001;
      end
    end
  end

  // Data ready output
  always_ff @(posedge clk) begin
    if (srst) begin
      dataReadyN <= 1'b1;
    end else if (ce) begin
      if (conversionDone & deliverOk) begin
        dataReadyN <= 1'b0;
      end else if (restart | dataRead | drdyEarly) begin
        dataReadyN <= 1'b1;
      end
    end
  end

  // Result word
  always_ff @(posedge clk) begin
    if (srst) begin
      dataWord <= '0;
    end else if (ce) begin
      if (conversionDone & deliverOk) begin
        dataWord <= corrOut;
      end
    end
  end

  // Analog routing and modulator power
  always_ff @(posedge clk) begin
    if (srst) begin
      analogInputSel <= INPUT_MIDSUPPLY;
      modulatorPowered <= 1'b1;
    end else if (ce) begin
      if ((next_state == ST_CAL_OFS) & ~calOfsSystem()) begin
        analogInputSel <= INPUT_MIDSUPPLY;
      end else if ((next_state == ST_CAL_GAIN) & ~calOfsSystem()) begin
        analogInputSel <= INPUT_REFERENCE;
      end else begin
        analogInputSel <= INPUT_SIGNAL;
      end
      modulatorPowered <= next_state != ST_STANDBY;
    end
  end

  // Calibration kind as it will be after this edge
  function automatic logic calOfsSystem();
    if (calOfsCmd | calGainCmd) begin
      calOfsSystem = (cmdCode == CMD_SYS_OFS) | (cmdCode == CMD_SYS_GAIN);
    end else begin
      calOfsSystem = calSystem;
    end
  endfunction : calOfsSystem

  // Gain divider
  always_ff @(posedge clk) begin
    if (srst) begin
      divStep <= '0;
      divisor <= '0;
      rem <= '0;
      quot <= '0;
      quotOvf <= 1'b0;
      gainBad <= 1'b0;
    end else if (ce) begin
      if ((state == ST_CAL_GAIN) & calDone) begin
        divisor <= gainProd[46:0];
        gainBad <= corrDiff <= 28'sh0;
        divStep <= '0;
        rem <= '0;
        quot <= '0;
        quotOvf <= 1'b0;
      end else if ((state == ST_DIVIDE) & (divStep != DIV_STEPS)) begin
        divStep <= divStep + 6'h01;
        rem <= trialGe ? trial - {1'b0, divisor} : trial;
        quot <= {quot[23:0], trialGe};
        quotOvf <= quotOvf | quot[24];
      end
    end
  end

  // Rate, offset and gain words
  always_ff @(posedge clk) begin
    if (srst) begin
      rateSel <= RATE_RESET;
      offsetWord <= OFFSET_RESET;
      gainWord <= GAIN_RESET;
    end else if (ce) begin
      if (apbWrite & (paddr == REG_RATE)) begin
        rateSel <= pwdata[3:0];
      end
      if ((state == ST_CAL_OFS) & calDone) begin
        offsetWord <= newOffset;
      end else if (apbWrite & (paddr == REG_OFFSET)) begin
        offsetWord <= pwdata[23:0];
      end
      if ((state == ST_DIVIDE) & (divStep == DIV_STEPS)) begin
        gainWord <= newGain;
      end else if (apbWrite & (paddr == REG_GAIN)) begin
        gainWord <= pwdata[23:0];
      end
    end
  end

  // Read mux and error decode
  always_comb begin
    readData = '0;
    readErr = 1'b0;
    writeErr = 1'b0;
    case (paddr)
      REG_CMD: begin
        readData = '0;
      end
      REG_RATE: begin
        readData = {28'h0, rateSel};
      end
      REG_OFFSET: begin
        readData = {8'h0, offsetWord};
      end
      REG_GAIN: begin
        readData = {8'h0, gainWord};
      end
      REG_DATA: begin
        readData = {8'h0, dataWord};
        writeErr = 1'b1;
      end
      REG_STATUS: begin
        readData[ST_BIT_READY] = ~dataReadyN;
        readData[ST_BIT_CAL] = (state == ST_CAL_OFS) |
          (state == ST_CAL_GAIN) | (state == ST_DIVIDE);
        readData[ST_BIT_STANDBY] = state == ST_STANDBY;
        readData[ST_BIT_ONESHOT] = oneShot;
        writeErr = 1'b1;
      end
      default: begin
        readErr = 1'b1;
        writeErr = 1'b1;
      end
    endcase
  end

  // APB answer, one access cycle with no wait
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel & ~penable) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0 : readData;
        pslverr <= pwrite ? writeErr : readErr;
      end else begin
        pready <= 1'b0;
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule : adc_conversion_and_calibration

/* File: verif/adc_cal_chk.sv */
// Checker for the conversion block's bus, ready and routing behaviour.
// Bound to the top module; sees only its ports.
`timescale 1ns/100ps
module adc_cal_chk
  import adc_cal_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dataReadyN,
  input wire logic [1:0] analogInputSel,
  input wire logic modulatorPowered
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic setup;
  logic cmdWr;
  assign setup = psel && !penable;
  assign cmdWr = psel && penable && pwrite && pready && paddr == REG_CMD;

  AST_PREADY_AFTER_SETUP: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_UNMAPPED_ERR: assert property (setup && paddr > REG_STATUS
    |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (setup && !pwrite
    && paddr <= REG_STATUS && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped read refused");
  AST_CAL_DATA_READY_N_HIGH: assert property (cmdWr
    && pwdata[3:0] inside {[CMD_SELF_OFS:CMD_SYS_GAIN]} |=> dataReadyN[*8])
    else $error("ready low during calibration");
  AST_SELF_OFS_MID: assert property (cmdWr
    && pwdata[3:0] == CMD_SELF_OFS
    |-> ##[1:2] analogInputSel == INPUT_MIDSUPPLY)
    else $error("offset cal not on mid-supply");
  AST_SELF_GAIN_REF: assert property (cmdWr
    && pwdata[3:0] == CMD_SELF_GAIN
    |-> ##[1:2] analogInputSel == INPUT_REFERENCE)
    else $error("gain cal not on reference");
  AST_WAKE_POWER: assert property (cmdWr && pwdata[3:0] == CMD_WAKEUP
    && !modulatorPowered |-> ##[1:2] modulatorPowered)
    else $error("wakeup did not power modulator");
  AST_STANDBY_OFF: assert property (cmdWr
    && pwdata[3:0] == CMD_STANDBY |-> ##[1:2] !modulatorPowered)
    else $error("standby left modulator on");
  AST_READ_WIDTH: assert property (pready && !pwrite
    && paddr == REG_DATA |-> prdata[31:24] == 8'h00)
    else $error("data wider than 24 bits");
  AST_RESET_CAL: assert property ($fell(srst) |-> dataReadyN[*8])
    else $error("ready low right after reset");

  cover property (setup && paddr > REG_STATUS);
  cover property ($fell(dataReadyN));
  cover property (analogInputSel == INPUT_REFERENCE);
endmodule : adc_cal_chk

bind adc_conversion_and_calibration adc_cal_chk chk (.clk(clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dataReadyN(dataReadyN),
  .analogInputSel(analogInputSel), .modulatorPowered(modulatorPowered));

/* File: verif/afe_model.sv */
// Front-end stand-in: free-running master clock and filter output.
// Routes the code by the block's analog input selection.
`timescale 1ns/100ps
module afe_model
  import adc_cal_pkg::*;
#(
  parameter logic [23:0] REF_CODE = 24'h400000
)(
  input wire logic [1:0] analogInputSel,
  input wire logic [23:0] signalCode,
  output logic masterClockInput,
  output logic [23:0] filterCode
);
  // Master clock, 800 ns, unrelated phase
  initial begin
    masterClockInput = 1'b0;
    #137;
    forever #400 masterClockInput = ~masterClockInput;
  end
  // Mid-supply reads zero, reference a fixed code
  always_comb begin
    case (analogInputSel)
      INPUT_MIDSUPPLY: filterCode = 24'h000000;
      INPUT_REFERENCE: filterCode = REF_CODE;
      default: filterCode = signalCode;
    endcase
  end
endmodule : afe_model

/* File: verif/testbench.sv */
// Self-checking bench: APB host tasks, one task per scenario.
// Assumes the front-end model supplies master clock and filter code.
`timescale 1ns/100ps
module testbench
  import adc_cal_pkg::*;
;
  logic clk, srst, psel, penable, pwrite, syncPowerdownN;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, dataReadyN, modulatorPowered, masterClockInput;
  logic [1:0] analogInputSel;
  logic [23:0] filterCode, sigCode;
  int err_count, tests_run, n, m;

  always #50 clk = ~clk;

  adc_conversion_and_calibration dut (.clk(clk), .srst(srst), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .masterClockInput(masterClockInput), .syncPowerdownN(syncPowerdownN),
    .filterCode(filterCode), .dataReadyN(dataReadyN),
    .analogInputSel(analogInputSel), .modulatorPowered(modulatorPowered));
  afe_model afe (.analogInputSel(analogInputSel), .signalCode(sigCode),
    .masterClockInput(masterClockInput), .filterCode(filterCode));

  task complete_run;
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_ready(input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dataReadyN !== lvl && n < 40000);
    if (n >= 40000) begin
      err_count++;
      complete_run();
    end
  endtask : wait_ready

  function logic [31:0] near(input int v, input int e);
    return {31'h0, v >= e - 24 && v <= e + 24};
  endfunction : near

  task reset_regs;
    apb(1'b0, REG_RATE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, REG_GAIN, 32'h0);
    chk(rd, 32'h0044ac08);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, REG_DATA, 32'h5);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, REG_OFFSET, 32'h123456);
    apb(1'b0, REG_OFFSET, 32'h0);
    chk(rd, 32'h123456);
    wait_ready(1'b0);
    chk({31'h0, n > 34000}, 32'h1);
    apb(1'b0, REG_OFFSET, 32'h0);
    chk(rd, 32'h0);
  endtask : reset_regs

  task one_shot;
    apb(1'b1, REG_CMD, {28'h0, CMD_STANDBY});
    repeat (3) @(posedge clk);
    chk({30'h0, modulatorPowered, dataReadyN}, 32'h1);
    apb(1'b1, REG_CMD, {28'h0, CMD_WAKEUP});
    wait_ready(1'b0);
    chk(near(n, 12288), 32'h1);
    apb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
  endtask : one_shot

  task continuous;
    syncPowerdownN <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, dataReadyN}, 32'h1);
    syncPowerdownN <= 1'b1;
    wait_ready(1'b0);
    chk(near(n, 10240), 32'h1);
    wait_ready(1'b1);
    m = n;
    wait_ready(1'b0);
    chk(near(n + m, 2048), 32'h1);
    apb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_GAIN, 32'hffffff);
    sigCode <= 24'h7fffff;
    apb(1'b1, REG_CMD, {28'h0, CMD_SYNC});
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CMD, {28'h0, CMD_WAKEUP});
    wait_ready(1'b0);
    chk(near(n, 10240), 32'h1);
    apb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h7fffff);
    sigCode <= 24'h800000;
    wait_ready(1'b0);
    apb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h800000);
  endtask : continuous

  task calibrate;
    logic [3:0] cmds [5];
    logic [1:0] sels [5];
    cmds = '{CMD_SELF_GAIN, CMD_SELF_FULL, CMD_SYS_GAIN, CMD_SELF_OFS,
      CMD_SYS_OFS};
    sels = '{INPUT_REFERENCE, INPUT_MIDSUPPLY, INPUT_SIGNAL,
      INPUT_MIDSUPPLY, INPUT_SIGNAL};
    apb(1'b1, REG_RATE, 32'h1);
    apb(1'b0, REG_RATE, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, REG_RATE, 32'h0);
    sigCode <= 24'h000200;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, REG_CMD, {28'h0, cmds[i]});
      repeat (3) @(posedge clk);
      chk({29'h0, dataReadyN, analogInputSel}, {29'h0, 1'b1, sels[i]});
    end
    wait_ready(1'b0);
    chk(near(n, 22525), 32'h1);
    apb(1'b0, REG_OFFSET, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, REG_DATA, 32'h0);
    chk(rd, 32'h0);
  endtask : calibrate

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    syncPowerdownN = 1'b1;
    sigCode = 24'h000000;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    reset_regs();
    one_shot();
    continuous();
    calibrate();
    complete_run();
  end
endmodule : testbench
